/* rtl/hbse_params.svh */
// Purpose: Constants for the half-bridge switch enable register bank.
// Assumes: 16-bit frame, least significant bit first, address byte then data byte.
`ifndef HBSE_PARAMS_SVH
`define HBSE_PARAMS_SVH

// ****************************************
// Frame layout
// ****************************************
`define HBSE_FRAME_BITS 5'h10
`define HBSE_ADDR_BITS 5'h08
`define HBSE_OP_BIT 7
`define HBSE_LSB_BIT 0
`define HBSE_SEL_HI 6
`define HBSE_SEL_LO 2

// ****************************************
// Register select codes (address bits 6..2)
// ****************************************
`define HBSE_SEL_ENABLE_A 5'h00
`define HBSE_SEL_ENABLE_B 5'h10
`define HBSE_SEL_ENABLE_C 5'h08
`define HBSE_SEL_PWM_A 5'h18

// ****************************************
// Fields and reset values
// ****************************************
`define HBSE_OUT4_ROUTE_HI 7
`define HBSE_OUT4_ROUTE_LO 6
`define HBSE_REG_RESET 8'h00

`endif

/* rtl/hbse_pkg.sv */
// Purpose: Types shared by the register bank files.
// Assumes: Constants come from hbse_params.svh.
// Notes: Routes are two-bit codes; output 4 is the only output with one.
`include "hbse_params.svh"

package hbse_pkg;

    // PWM route of one output
    typedef enum logic [1:0]
    {
        HBSE_ROUTE_NONE = 2'h0,
        HBSE_ROUTE_PWM1 = 2'h1,
        HBSE_ROUTE_PWM2 = 2'h2,
        HBSE_ROUTE_PWM3 = 2'h3
    } hbse_route_t;

    // Serial pins as seen by the core
    typedef struct packed
    {
        logic csn;
        logic sclk;
        logic sdi;
    } hbse_pins_t;

    // Control registers
    typedef struct packed
    {
        logic [7:0] enable_a;
        logic [7:0] enable_b;
        logic [7:0] enable_c;
        logic [7:0] pwm_a;
    } hbse_regs_t;

    // Switch drive outputs
    typedef struct packed
    {
        logic [11:0] upper_switch_on;
        logic [11:0] lower_switch_on;
        hbse_route_t output4_pwm_route;
        logic [7:0] pwm_select;
    } hbse_drive_t;

endpackage

/* rtl/hbse_pin_sync.sv */
// Purpose: Three-stage synchroniser for the serial pins.
// Assumes: Pins are asynchronous to clock.
// Notes: A change counts once stages two and three agree.
`timescale 1ns/1ns

module hbse_pin_sync
    import hbse_pkg::*;
#(
    parameter int WIDTH = 3
)
(
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Raw and filtered levels
    input wire logic [WIDTH-1:0] pin_raw,
    output logic [WIDTH-1:0] pin_level
);

    // ****************************************
    // State
    // ****************************************
    typedef struct packed
    {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
        logic [WIDTH-1:0] stage3;
        logic [WIDTH-1:0] level;
    } hbse_sync_t;

    hbse_sync_t state; // Registered state
    hbse_sync_t next_state; // Next state

    // Stage shifting, filter per bit
    always_comb
    begin
        next_state = state;
        next_state.stage1 = pin_raw;
        next_state.stage2 = state.stage1;
        next_state.stage3 = state.stage2;
        for (int i = 0; i < WIDTH; i++)
        begin
            // Accept only when stages agree
            if (state.stage2[i] == state.stage3[i])
            begin
                next_state.level[i] = state.stage3[i];
            end
        end
    end

    // Registers; idle levels 0 (chip select idle high is set by caller)
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            state <= '0;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign pin_level = state.level;

endmodule

/* rtl/hbse_regs.sv */
// Purpose: Half-bridge enable and PWM select registers behind a serial frame.
// Assumes: Host is frame master; sdi sampled on sclk rise, sdo changes on fall.
// Notes: Bridge drive outputs lag the register by one clock.
`timescale 1ns/1ns
`include "hbse_params.svh"

// ****************************************
// Frame overview
// ****************************************
// Sixteen bits per frame, least significant bit first
// Bits 0..7: address byte, bits 8..15: data byte
// Address bit 0 must be set for a write, bit 1 is ignored
// Address bits 6..2 pick the register
// Address bit 7 set: write, clear: read
// Read data leaves on sdo during the data byte
// Writes land only when select returns high
// Short, long or malformed frames change nothing
// Pins cross into the clock domain first
// Every pin edge is therefore seen a few clocks late

module hbse_regs
    import hbse_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Serial pins
    input wire logic csn,
    input wire logic sclk,
    input wire logic sdi,
    output logic sdo,
    output logic sdo_oe,
    // Bridge drive
    output logic [11:0] upper_switch_on,
    output logic [11:0] lower_switch_on,
    output hbse_route_t output4_pwm_route,
    output logic [7:0] pwm_select
);

    // ****************************************
    // Pin synchronisation
    // ****************************************
    hbse_pins_t pins; // Filtered pin levels
    logic [2:0] pins_raw; // Inverted chip select so idle reset is safe
    logic [2:0] pins_level; // Synchroniser output

    // Select is inverted into the filter so that
    // the all-zero reset of the filter reads as idle
    assign pins_raw = {~csn, sclk, sdi};

    // Three stages per pin; the third confirms the second
    // so a single-clock glitch never reaches the frame engine
    hbse_pin_sync #(.WIDTH(3)) u_sync
    (
        .clock(clock),
        .rstn(rstn),
        .pin_raw(pins_raw),
        .pin_level(pins_level)
    );

    assign pins = '{csn: ~pins_level[2], sclk: pins_level[1], sdi: pins_level[0]};

    // ****************************************
    // State
    // ****************************************
    // One packed record holds every flip-flop
    // so one register process covers them all
    typedef struct packed
    {
        logic csn_prev;
        logic sclk_prev;
        logic [15:0] shift;
        logic [4:0] count;
        logic [7:0] tx;
        logic sdo;
        logic sdo_oe;
        hbse_regs_t regs;
        hbse_drive_t drive;
    } hbse_core_t;

    hbse_core_t state; // Registered state
    hbse_core_t next_state; // Next state

    // ****************************************
    // Frame engine
    // ****************************************
    // Edges are taken from the filtered levels only
    // The raw pins may glitch; the filter hides that
    // The read mux follows the upper shift byte, which
    // holds the address once eight bits are in
    // The drive stage lags the registers by one clock
    // Frame engine, register update and bridge drive
    always_comb
    begin
        logic [7:0] addr;
        logic [4:0] sel;
        logic [7:0] rd;
        logic [23:0] en_all;
        addr = '0;
        sel = '0;
        rd = '0;
        en_all = '0;
        next_state = state;
        // Edge history of the filtered pins
        next_state.csn_prev = pins.csn;
        next_state.sclk_prev = pins.sclk;
        // Upper byte holds the address after eight bits
        addr = state.shift[15:8];
        sel = addr[`HBSE_SEL_HI:`HBSE_SEL_LO];
        // Read-back of addressed register
        case (sel)
            `HBSE_SEL_ENABLE_A: rd = state.regs.enable_a;
            `HBSE_SEL_ENABLE_B: rd = state.regs.enable_b;
            `HBSE_SEL_ENABLE_C: rd = state.regs.enable_c;
            `HBSE_SEL_PWM_A: rd = state.regs.pwm_a;
            default: rd = '0;
        endcase
        if (state.csn_prev && !pins.csn)
        begin
            // Frame start
            next_state.shift = '0;
            next_state.count = '0;
            next_state.sdo = 1'b0;
            next_state.sdo_oe = 1'b1;
        end
        else if (!pins.csn)
        begin
            if (!state.sclk_prev && pins.sclk)
            begin
                // Rising edge: sample, least significant bit first
                next_state.shift = {pins.sdi, state.shift[15:1]};
                // Saturate so an overlong frame stays refused
                if (state.count != 5'h1F)
                begin
                    next_state.count = state.count + 5'h01;
                end
            end
            else if (state.sclk_prev && !pins.sclk)
            begin
                // Falling edge: drive response during data byte
                // Eighth fall: load the read byte
                if (state.count == `HBSE_ADDR_BITS)
                begin
                    next_state.sdo = rd[0];
                    next_state.tx = {1'b0, rd[7:1]};
                end
                else if (state.count > `HBSE_ADDR_BITS && state.count < `HBSE_FRAME_BITS)
                begin
                    next_state.sdo = state.tx[0];
                    next_state.tx = {1'b0, state.tx[7:1]};
                end
            end
        end
        else if (!state.csn_prev && pins.csn)
        begin
            // Frame end: commit only a whole, well-formed write
            next_state.sdo_oe = 1'b0;
            next_state.sdo = 1'b0;
            if (state.count == `HBSE_FRAME_BITS && state.shift[`HBSE_LSB_BIT] &&
                state.shift[`HBSE_OP_BIT])
            begin
                case (state.shift[`HBSE_SEL_HI:`HBSE_SEL_LO])
                    `HBSE_SEL_ENABLE_A: next_state.regs.enable_a = state.shift[15:8];
                    `HBSE_SEL_ENABLE_B: next_state.regs.enable_b = state.shift[15:8];
                    `HBSE_SEL_ENABLE_C: next_state.regs.enable_c = state.shift[15:8];
                    `HBSE_SEL_PWM_A: next_state.regs.pwm_a = state.shift[15:8];
                    default: next_state.regs = state.regs;
                endcase
            end
        end
        // Bridge n uses bits 2n-1 (upper) and 2n-2 (lower)
        // Interlock acts on the drive; the register keeps both bits
        en_all = {state.regs.enable_c, state.regs.enable_b, state.regs.enable_a};
        for (int i = 0; i < 12; i++)
        begin
            // Both set: whole bridge off
            if (en_all[2*i+1] && en_all[2*i])
            begin
                next_state.drive.upper_switch_on[i] = 1'b0;
                next_state.drive.lower_switch_on[i] = 1'b0;
            end
            else
            begin
                next_state.drive.upper_switch_on[i] = en_all[2*i+1];
                next_state.drive.lower_switch_on[i] = en_all[2*i];
            end
        end
        // Code 11 selects channel 3
        next_state.drive.output4_pwm_route =
            hbse_route_t'(state.regs.pwm_a[`HBSE_OUT4_ROUTE_HI:`HBSE_OUT4_ROUTE_LO]);
        next_state.drive.pwm_select = state.regs.pwm_a;
    end

    // ****************************************
    // Register bank
    // ****************************************
    // Reset branch loads constants only
    // Select history starts high to match the idle pin
    // State registers, all zero at reset except the select history, which starts high
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            state <= '0;
            state.csn_prev <= 1'b1;
            state.regs <= {4{`HBSE_REG_RESET}};
        end
        else
        begin
            state <= next_state;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    // Each output is a flip-flop of the state record
    assign sdo = state.sdo;
    assign sdo_oe = state.sdo_oe;
    assign upper_switch_on = state.drive.upper_switch_on;
    assign lower_switch_on = state.drive.lower_switch_on;
    assign output4_pwm_route = state.drive.output4_pwm_route;
    assign pwm_select = state.drive.pwm_select;

endmodule

/* tb/hbse_regs_monitor.sv */
// Purpose: Checker on the register bank ports.
// Assumes: Pins change away from the rising edge.
// Notes: Counts clocks since select release.
`timescale 1ns/1ns
module hbse_regs_monitor
    import hbse_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Serial pins
    input wire logic csn,
    input wire logic sclk,
    input wire logic sdi,
    input wire logic sdo,
    input wire logic sdo_oe,
    // Bridge drive
    input wire logic [11:0] upper_switch_on,
    input wire logic [11:0] lower_switch_on,
    input wire hbse_route_t output4_pwm_route,
    input wire logic [7:0] pwm_select
);
    // Clocks since frame end, saturating
    logic [3:0] since_rise;
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    // Restart count while selected
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            since_rise <= 4'h0;
        else if (!csn)
            since_rise <= 4'h0;
        else if (since_rise != 4'hF)
            since_rise <= since_rise + 4'h1;
    end
    a_no_cross: assert property ((upper_switch_on & lower_switch_on) == 12'h000)
        else $error("bridge both sides on");
    a_route_field: assert property (output4_pwm_route == pwm_select[7:6])
        else $error("route not mode field");
    a_reset_clear: assert property ($rose(rstn) |-> !(|{upper_switch_on, lower_switch_on, pwm_select}))
        else $error("outputs not clear");
    a_upper_commit: assert property ($changed(upper_switch_on) |-> since_rise inside {[4'h1:4'hC]})
        else $error("upper change outside commit");
    a_lower_commit: assert property ($changed(lower_switch_on) |-> since_rise inside {[4'h1:4'hC]})
        else $error("lower change outside commit");
    a_mode_commit: assert property ($changed(pwm_select) |-> since_rise inside {[4'h1:4'hC]})
        else $error("mode change outside commit");
    a_oe_on_frame: assert property ($fell(csn) |-> ##[2:8] sdo_oe)
        else $error("sdo not driven");
    a_sdo_idle: assert property (since_rise == 4'hF |-> !sdo_oe && !sdo)
        else $error("sdo driven when idle");
    c_upper_on: cover property ($rose(|upper_switch_on));
    c_route3: cover property (output4_pwm_route == HBSE_ROUTE_PWM3);
    c_read: cover property ($rose(sdo));
endmodule

bind hbse_regs hbse_regs_monitor mon (.clock(clock), .rstn(rstn), .csn(csn), .sclk(sclk), .sdi(sdi),
    .sdo(sdo), .sdo_oe(sdo_oe), .upper_switch_on(upper_switch_on), .lower_switch_on(lower_switch_on),
    .output4_pwm_route(output4_pwm_route), .pwm_select(pwm_select));

/* tb/hbse_host_model.sv */
// Purpose: Frame master standing for the controller.
// Assumes: Phases of six clocks.
// Notes: Idle pins rest at pull levels.
`timescale 1ns/1ns
module hbse_host_model
(
    // Clock
    input wire logic clock,
    // Frame pins
    output logic csn,
    output logic sclk,
    output logic sdi,
    input wire logic sdo,
    input wire logic sdo_oe
);
    initial
    begin
        csn = 1'b1;
        sclk = 1'b0;
        sdi = 1'b0;
    end
    // Address then data, low bit first
    task automatic frame(input logic [7:0] a, input logic [7:0] d, input int n, output logic [7:0] rd);
        logic [15:0] w;
        w = {d, a};
        rd = 8'h00;
        @(negedge clock) csn = 1'b0;
        repeat (6) @(negedge clock);
        for (int i = 0; i < n; i++)
        begin
            sdi = w[i];
            repeat (6) @(negedge clock);
            if (i > 7)
                rd[i-8] = sdo_oe ? sdo : ~sdo;
            sclk = 1'b1;
            repeat (6) @(negedge clock);
            sclk = 1'b0;
        end
        repeat (6) @(negedge clock);
        csn = 1'b1;
        sdi = 1'b0;
        repeat (12) @(negedge clock);
    endtask
endmodule

/* tb/tb_top.sv */
// Purpose: Self-checking bench for the bridge registers.
// Assumes: Host model drives the frame pins.
// Notes: Expected drive rebuilt from shadow bytes.
`timescale 1ns/1ns
module tb_top
    import hbse_pkg::*;
;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic csn, sclk, sdi, sdo, sdo_oe;
    logic [11:0] upper_switch_on, lower_switch_on;
    hbse_route_t output4_pwm_route;
    logic [7:0] pwm_select, rd;
    logic [7:0] ex_a = 8'h00, ex_b = 8'h00, ex_c = 8'h00, ex_p = 8'h00;
    int failures = 0;
    int samples_checked = 0;
    always #4 clock = ~clock;
    hbse_regs uut (.clock(clock), .rstn(rstn), .csn(csn), .sclk(sclk), .sdi(sdi), .sdo(sdo),
        .sdo_oe(sdo_oe), .upper_switch_on(upper_switch_on), .lower_switch_on(lower_switch_on),
        .output4_pwm_route(output4_pwm_route), .pwm_select(pwm_select));
    hbse_host_model host (.clock(clock), .csn(csn), .sclk(sclk), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe));
    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            failures++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // Interlocked drive from shadow registers
    task automatic check_all();
        logic [23:0] r;
        logic [11:0] hi, lo;
        r = {ex_c, ex_b, ex_a};
        for (int k = 0; k < 12; k++)
        begin
            hi[k] = r[2*k+1] & ~r[2*k];
            lo[k] = r[2*k] & ~r[2*k+1];
        end
        chk(upper_switch_on, hi);
        chk(lower_switch_on, lo);
        chk({4'h0, pwm_select}, {4'h0, ex_p});
        chk({10'h000, output4_pwm_route}, {10'h000, ex_p[7:6]});
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host.frame(a, d, 16, rd);
        check_all();
    endtask
    task automatic t_groups();
        ex_a = 8'h4D;
        wr(8'h81, ex_a);
        ex_b = 8'h81;
        wr(8'hC1, ex_b);
        ex_c = 8'hE6;
        wr(8'hA1, ex_c);
        ex_a = 8'h12;
        wr(8'h83, ex_a);
        ex_a = 8'h00;
        wr(8'h81, ex_a);
    endtask
    task automatic t_modes();
        for (int m = 0; m < 4; m++)
        begin
            ex_p = {m[1:0], 6'h1B};
            wr(8'hE1, ex_p);
        end
    endtask
    // Refused frames leave all registers
    task automatic t_refused();
        host.frame(8'h81, 8'hFF, 12, rd);
        host.frame(8'h61, 8'h00, 16, rd);
        chk({4'h0, rd}, {4'h0, ex_p});
        host.frame(8'h80, 8'hFF, 16, rd);
        host.frame(8'h41, 8'hFF, 16, rd);
        chk({4'h0, rd}, {4'h0, ex_b});
        host.frame(8'h85, 8'hFF, 16, rd);
        host.frame(8'h05, 8'hFF, 16, rd);
        chk({4'h0, rd}, 12'h000);
        check_all();
    endtask
    initial
    begin
        repeat (12) @(negedge clock);
        rstn = 1'b1;
        repeat (6) @(negedge clock);
        check_all();
        t_groups();
        t_modes();
        t_refused();
        repeat (20) @(negedge clock);
        finish_test();
    end
    initial
    begin
        #200000;
        failures++;
        finish_test();
    end
endmodule
